// ==== logic/angle_sensor_register_bank.sv ====
`include "angle_sensor_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module angle_sensor_register_bank (
    // System
    input wire logic clk,
    input wire logic rst,
    // Serial link from the host
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEnN,
    // Sensor core
    input wire angle_sensor_pkg::sensorData_type sensorData,
    output angle_sensor_pkg::nvSettings_type nvSettings,
    output logic otpProgrammed
);

    // ****************************************
    // Declarations
    // ****************************************
    logic csnMeta_q, csnSync_q, csnLast_q;
    logic linkClear_q;
    logic frameEnd;
    logic [15:0] rxShift_q;
    logic [4:0] rxCount_q;
    logic [3:0] txPtr_q;
    logic serialOut_q, serialOutEnN_q;
    logic [15:0] txWord_q;
    angle_sensor_pkg::linkPhase_type phase_q;
    logic [13:0] wrAddr_q;
    logic [2:0] errFlags_q, errFlags_d;
    logic [13:0] progCtrl_q;
    logic [`NV_COUNT-1:0][7:0] nvWork_q;
    // Burned store has no reset: it must outlive every hardware reset
    logic [`NV_COUNT-1:0][7:0] otpStore_q = '0;
    logic otpBurned_q = 1'b0;
    angle_sensor_pkg::cmdWord_type rxCmd;
    logic lenOk, parOk, cmdOk, dataOk;
    logic [2:0] newErr;
    logic [13:0] lookAddr;
    logic rdValid, rdWritable;
    logic [13:0] rdData, wrMask;
    logic [2:0] nvIdx;
    logic [13:0] diagWord;
    logic [13:0] txData;
    logic burnReq, reloadReq, progWrite;

    localparam logic [`NV_COUNT-1:0][7:0] NV_MASK = {
        `MASK_REDUNDANCY, `MASK_CONFIG_TWO, `MASK_CONFIG_ONE, `MASK_ZERO_LOW, `MASK_ZERO_HIGH
    };

    // ****************************************
    // Chip select crossing into clk
    // ****************************************

    // Two stages before any clk logic reads select. The link clear follows one
    // cycle after frame end and drops about three cycles after select falls,
    // so the host must wait that long before its first serial edge
    always_ff @(posedge clk) begin
        if (rst) begin
            csnMeta_q <= 1'b1;
            csnSync_q <= 1'b1;
            csnLast_q <= 1'b1;
            linkClear_q <= 1'b1;
        end else begin
            csnMeta_q <= chipSelN;
            csnSync_q <= csnMeta_q;
            csnLast_q <= csnSync_q;
            linkClear_q <= csnSync_q & csnLast_q;
        end
    end

    assign frameEnd = csnSync_q & ~csnLast_q;

    // ****************************************
    // Link side, serial clock domain
    // ****************************************

    // Input sampled on the falling serial edge; count saturates
    always_ff @(negedge serialClk or posedge linkClear_q) begin
        if (linkClear_q) begin
            rxShift_q <= '0;
            rxCount_q <= '0;
        end else begin
            rxShift_q <= {rxShift_q[14:0], serialIn};
            if (rxCount_q != 5'h1f) begin
                rxCount_q <= rxCount_q + 5'h01;
            end
        end
    end

    // Output bits launched on the rising edge, MSB first;
    // the answer word is steady for the whole frame
    always_ff @(posedge serialClk or posedge linkClear_q) begin
        if (linkClear_q) begin
            txPtr_q <= `TX_LAST;
            serialOut_q <= 1'b0;
        end else begin
            serialOut_q <= txWord_q[txPtr_q];
            txPtr_q <= txPtr_q - 4'h1;
        end
    end

    // Release the output as soon as select rises, without waiting for a clock
    always_ff @(posedge serialClk or posedge chipSelN) begin
        if (chipSelN) begin
            serialOutEnN_q <= 1'b1;
        end else begin
            serialOutEnN_q <= 1'b0;
        end
    end

    assign serialOut = serialOut_q;
    assign serialOutEnN = serialOutEnN_q;

    // ****************************************
    // Frame checks, clk domain
    // ****************************************

    // Shift register is quasi-static here: the serial clock has stopped
    always_comb begin
        rxCmd = angle_sensor_pkg::cmdWord_type'(rxShift_q);
        lenOk = (rxCount_q == `FRAME_BITS);
        parOk = ~(^rxShift_q);
        newErr = `ERR_ZERO;
        newErr[`BIT_FRAME_FAULT] = frameEnd & (~lenOk |
            (phase_q == angle_sensor_pkg::PHASE_DATA & rxCmd.readNotWrite));
        newErr[`BIT_PARITY_FAULT] = frameEnd & lenOk & ~parOk;
        newErr[`BIT_ADDR_FAULT] = frameEnd & lenOk & parOk &
            (phase_q == angle_sensor_pkg::PHASE_CMD) & ~rdValid;
        cmdOk = frameEnd & lenOk & parOk & (phase_q == angle_sensor_pkg::PHASE_CMD) & rdValid;
        dataOk = frameEnd & lenOk & parOk & (phase_q == angle_sensor_pkg::PHASE_DATA) &
            ~rxCmd.readNotWrite;
    end

    // ****************************************
    // Address decode and read values
    // ****************************************

    always_comb begin
        diagWord = `REG_ZERO;
        diagWord[`DIAG_WEAK] = (sensorData.gainValue == `GAIN_MAX);
        diagWord[`DIAG_STRONG] = (sensorData.gainValue == `GAIN_MIN);
        diagWord[`DIAG_OVERFLOW] = sensorData.solverOverflow;
        diagWord[`DIAG_LOOPS] = sensorData.loopsDone;
        diagWord[7:0] = sensorData.gainValue;
    end

    // One lookup serves both the command and the pending write address
    always_comb begin
        lookAddr = (phase_q == angle_sensor_pkg::PHASE_DATA) ? wrAddr_q : rxCmd.addr;
        nvIdx = 3'(lookAddr - `ADDR_ZERO_HIGH);
        rdValid = 1'b1;
        rdWritable = 1'b0;
        rdData = `REG_ZERO;
        wrMask = `REG_ZERO;
        case (lookAddr)
            `ADDR_IDLE: rdData = `REG_ZERO;
            `ADDR_ERROR: rdData[2:0] = errFlags_q;
            `ADDR_OTP_CONTROL_REGISTER: begin
                rdData = progCtrl_q;
                rdWritable = 1'b1;
                wrMask = `OTP_CONTROL_REGISTER_STORE_MASK;
            end
            `ADDR_ZERO_HIGH, `ADDR_ZERO_LOW, `ADDR_CONFIG_ONE, `ADDR_CONFIG_TWO,
            `ADDR_REDUNDANCY: begin
                // Verify-select shows the burned values instead of the working copy
                rdData[7:0] = progCtrl_q[`OTP_CONTROL_REGISTER_VERIFY] ? otpStore_q[nvIdx] :
                    nvWork_q[nvIdx];
                rdWritable = 1'b1;
                wrMask[7:0] = NV_MASK[nvIdx];
            end
            `ADDR_DIAG: rdData = diagWord;
            `ADDR_MAGNITUDE: rdData = sensorData.magnitude;
            `ADDR_RAW_ANGLE: rdData = sensorData.rawAngle;
            `ADDR_COMP_ANGLE: begin
                rdData = nvWork_q[`NV_CONFIG_ONE][`CONFIG_SELECT_RAW] ? sensorData.rawAngle :
                    sensorData.compAngle;
            end
            default: rdValid = 1'b0;
        endcase
    end

    // ****************************************
    // Link phase and answer word
    // ****************************************

    // A write command arms the data phase; any data frame ends it
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= angle_sensor_pkg::PHASE_CMD;
            wrAddr_q <= `REG_ZERO;
        end else if (frameEnd) begin
            case (phase_q)
                angle_sensor_pkg::PHASE_CMD: begin
                    // An unmapped write still swallows its data frame, as the host expects
                    if (lenOk & parOk & ~rxCmd.readNotWrite) begin
                        phase_q <= angle_sensor_pkg::PHASE_DATA;
                        wrAddr_q <= rxCmd.addr;
                    end
                end
                angle_sensor_pkg::PHASE_DATA: phase_q <= angle_sensor_pkg::PHASE_CMD;
                default: phase_q <= angle_sensor_pkg::PHASE_CMD;
            endcase
        end
    end

    // Old content goes out during the data frame, new content after it
    always_comb begin
        txData = `REG_ZERO;
        if (dataOk) begin
            txData = rdWritable ? (rxShift_q[13:0] & wrMask) : rdData;
        end else if (cmdOk) begin
            txData = rdData;
        end
    end

    // Captured at the rising select edge, shifted out next frame
    always_ff @(posedge clk) begin
        if (rst) begin
            txWord_q <= '0;
        end else if (frameEnd) begin
            txWord_q <= {^{|newErr, txData}, |newErr, txData};
        end
    end

    // ****************************************
    // Error flags
    // ****************************************

    // New faults win over the clear of a read of this register
    always_comb begin
        errFlags_d = errFlags_q;
        if (cmdOk & rxCmd.readNotWrite & (rxCmd.addr == `ADDR_ERROR)) begin
            errFlags_d = `ERR_ZERO;
        end
        errFlags_d = errFlags_d | newErr;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            errFlags_q <= `ERR_ZERO;
        end else begin
            errFlags_q <= errFlags_d;
        end
    end

    // ****************************************
    // Programming control
    // ****************************************

    assign progWrite = dataOk & (wrAddr_q == `ADDR_OTP_CONTROL_REGISTER);
    // Burn and reload are strobes gated by the stored enable bit
    assign burnReq = progWrite & rxShift_q[`OTP_CONTROL_REGISTER_BURN] & progCtrl_q[`OTP_CONTROL_REGISTER_ENABLE] &
        ~otpBurned_q;
    assign reloadReq = progWrite & rxShift_q[`OTP_CONTROL_REGISTER_RELOAD] &
        progCtrl_q[`OTP_CONTROL_REGISTER_ENABLE] & ~burnReq;

    // Only enable and verify-select are kept; strobe bits read back as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            progCtrl_q <= `REG_ZERO;
        end else if (progWrite) begin
            progCtrl_q <= rxShift_q[13:0] & `OTP_CONTROL_REGISTER_STORE_MASK;
        end
    end

    // Once set, nothing in the design clears this flag
    always_ff @(posedge clk) begin
        if (burnReq) begin
            otpBurned_q <= 1'b1;
        end
    end

    assign otpProgrammed = otpBurned_q;

    // ****************************************
    // Non-volatile settings, one per entry
    // ****************************************

    for (genvar i = 0; i < `NV_COUNT; i++) begin : g_nv
        // Working copy: soft writes, reload, and restore at reset
        always_ff @(posedge clk) begin
            if (rst) begin
                nvWork_q[i] <= otpStore_q[i];
            end else if (reloadReq) begin
                nvWork_q[i] <= otpStore_q[i];
            end else if (dataOk & (wrAddr_q == `ADDR_ZERO_HIGH + 14'(i))) begin
                nvWork_q[i] <= rxShift_q[7:0] & NV_MASK[i];
            end
        end

        // Burned store starts all zero and takes one snapshot only
        always_ff @(posedge clk) begin
            if (burnReq) begin
                otpStore_q[i] <= nvWork_q[i];
            end
        end
    end

    assign nvSettings = angle_sensor_pkg::nvSettings_type'({nvWork_q[0], nvWork_q[1],
        nvWork_q[2], nvWork_q[3], nvWork_q[4]});

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_goodRead(logic [13:0] a);
        cmdOk && rxCmd.readNotWrite && (rxCmd.addr == a);
    endsequence

    sequence s_cmdFrame;
        frameEnd && lenOk && parOk && (phase_q == angle_sensor_pkg::PHASE_CMD);
    endsequence

    property p_nopQuiet;
        s_goodRead(`ADDR_IDLE) |=>
            (errFlags_q == $past(errFlags_q)) && (txWord_q[14:0] == 15'h0000);
    endproperty
    a_nopQuiet: assert property (p_nopQuiet) else $error("idle read had an effect");
    property p_errClear;
        s_goodRead(`ADDR_ERROR) |=>
            (errFlags_q == `ERR_ZERO) && (txWord_q[2:0] == $past(errFlags_q));
    endproperty
    a_errClear: assert property (p_errClear) else $error("error read did not clear");
    property p_badAddr;
        s_cmdFrame ##0 !rdValid |=> errFlags_q[`BIT_ADDR_FAULT] && txWord_q[14];
    endproperty
    a_badAddr: assert property (p_badAddr)
        else $error("bad address not flagged");
    property p_frameShape;
        frameEnd && !lenOk |=>
            errFlags_q[`BIT_FRAME_FAULT] && (phase_q == angle_sensor_pkg::PHASE_CMD);
    endproperty
    a_frameShape: assert property (p_frameShape) else $error("bad frame not flagged");
    property p_parity;
        frameEnd && lenOk && !parOk |=> errFlags_q[`BIT_PARITY_FAULT] && txWord_q[14];
    endproperty
    a_parity: assert property (p_parity) else $error("parity fault not flagged");
    property p_weak;
        s_goodRead(`ADDR_DIAG) ##0 (sensorData.gainValue == `GAIN_MAX) |=>
            txWord_q[`DIAG_WEAK] && !txWord_q[`DIAG_STRONG];
    endproperty
    a_weak: assert property (p_weak) else $error("weak field not reported");
    property p_strong;
        s_goodRead(`ADDR_DIAG) ##0 (sensorData.gainValue == `GAIN_MIN) |=>
            txWord_q[`DIAG_STRONG] && !txWord_q[`DIAG_WEAK];
    endproperty
    a_strong: assert property (p_strong) else $error("strong field not reported");
    property p_burnOnce;
        otpBurned_q |=> otpBurned_q && $stable(otpStore_q);
    endproperty
    a_burnOnce: assert property (p_burnOnce) else $error("burned store changed");
    property p_reload;
        reloadReq |=> (nvWork_q == otpStore_q) ##1 (nvSettings == $past(nvSettings));
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not restore");
    property p_answerParity;
        frameEnd |=> (^txWord_q == 1'b0) ##1 $stable(txWord_q);
    endproperty
    a_answerParity: assert property (p_answerParity)
        else $error("answer parity wrong");

endmodule // angle_sensor_register_bank

`default_nettype wire

// ==== inc/angle_sensor_regs.svh ====
`ifndef ANGLE_SENSOR_REGS_SVH
`define ANGLE_SENSOR_REGS_SVH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_IDLE 14'h0000
`define ADDR_ERROR 14'h0001
`define ADDR_OTP_CONTROL_REGISTER 14'h0003
`define ADDR_ZERO_HIGH 14'h0016
`define ADDR_ZERO_LOW 14'h0017
`define ADDR_CONFIG_ONE 14'h0018
`define ADDR_CONFIG_TWO 14'h0019
`define ADDR_REDUNDANCY 14'h001a
`define ADDR_DIAG 14'h3ffc
`define ADDR_MAGNITUDE 14'h3ffd
`define ADDR_RAW_ANGLE 14'h3ffe
`define ADDR_COMP_ANGLE 14'h3fff

// ****************************************
// Field positions, masks and values
// ****************************************
`define NV_COUNT 5
`define FRAME_BITS 5'h10
`define BIT_FRAME_FAULT 0
`define BIT_ADDR_FAULT 1
`define BIT_PARITY_FAULT 2
`define OTP_CONTROL_REGISTER_ENABLE 0
`define OTP_CONTROL_REGISTER_RELOAD 2
`define OTP_CONTROL_REGISTER_BURN 3
`define OTP_CONTROL_REGISTER_VERIFY 6
`define OTP_CONTROL_REGISTER_STORE_MASK 14'h0041
`define MASK_ZERO_HIGH 8'hff
`define MASK_ZERO_LOW 8'hff
`define MASK_CONFIG_ONE 8'hdf
`define MASK_CONFIG_TWO 8'h3f
`define MASK_REDUNDANCY 8'h1f
`define CONFIG_SELECT_RAW 6
`define NV_CONFIG_ONE 2
`define DIAG_WEAK 11
`define DIAG_STRONG 10
`define DIAG_OVERFLOW 9
`define DIAG_LOOPS 8
`define GAIN_MAX 8'hff
`define GAIN_MIN 8'h00
`define REG_ZERO 14'h0000
`define ERR_ZERO 3'h0
`define NV_ZERO 8'h00
`define TX_LAST 4'hf

`endif

// ==== inc/angle_sensor_pkg.sv ====
package angle_sensor_pkg;

    // Command or write-data word as it arrives on the serial input
    typedef struct packed {
        logic parity;
        logic readNotWrite;
        logic [13:0] addr;
    } cmdWord_type;

    // Live measurement values from the sensor core
    typedef struct packed {
        logic [7:0] gainValue;
        logic loopsDone;
        logic solverOverflow;
        logic [13:0] magnitude;
        logic [13:0] rawAngle;
        logic [13:0] compAngle;
    } sensorData_type;

    // Working copy of the non-volatile settings
    typedef struct packed {
        logic [7:0] zeroHigh;
        logic [7:0] zeroLowDiag;
        logic [7:0] configOne;
        logic [7:0] configTwo;
        logic [7:0] redundancy;
    } nvSettings_type;

    // Which word the next frame carries
    typedef enum logic [1:0] {
        PHASE_CMD = 2'b01,
        PHASE_DATA = 2'b10
    } linkPhase_type;

endpackage

// ==== tb/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host master on the serial link
// ****************************************
module spi_host_model (
    // Link to the device
    output logic serialClk,
    output logic chipSelN,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEnN
);
    // Idle: select high, clock low
    initial begin
        serialClk = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end

    // One frame of n bits, MSB first; clock stands still between frames
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] a);
        a = 16'h0000;
        chipSelN = 1'b0;
        #350; // Lead time: the link clear drops only some system clocks after select
        for (int i = n - 1; i >= 0; i--) begin
            #3 serialClk = 1'b1;
            serialIn = w[i];
            #3 serialClk = 1'b0;
            a[i] = serialOutEnN ? 1'bz : serialOut; // Released line never matches
        end
        #3 chipSelN = 1'b1;
        serialIn = ~serialIn; // No stale level once deselected
        #200; // Select gap well above six system clocks
    endtask
endmodule // spi_host_model

`default_nettype wire

// ==== tb/tb_angle_sensor_register_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "angle_sensor_regs.svh"

// Compare one value, count it, report a mismatch
`define CHK(nm, ex, got) begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
        fails++; \
        $display("[ERR] %s exp %h got %h", nm, ex, got); \
    end \
end

// ****************************************
// Register bank bench
// ****************************************
module tb_angle_sensor_register_bank;
    logic clk, rst, serialClk, chipSelN, serialIn, serialOut, serialOutEnN, otpProgrammed;
    angle_sensor_pkg::sensorData_type sensorData;
    angle_sensor_pkg::nvSettings_type nvSettings;
    int fails = 0;
    int num_checks = 0;
    logic [15:0] ans;
    logic [13:0] val;
    logic [7:0] gains [3] = '{8'h80, 8'hff, 8'h00};

    angle_sensor_register_bank angle_sensor_register_bank_inst (
        .clk(clk), .rst(rst), .serialClk(serialClk), .chipSelN(chipSelN),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
        .sensorData(sensorData), .nvSettings(nvSettings), .otpProgrammed(otpProgrammed));

    spi_host_model spi_host_model_inst (
        .serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEnN(serialOutEnN));

    // 50 MHz system clock
    initial clk = 1'b0;
    always #10 clk = ~clk;

    function automatic logic [15:0] cmd(input logic rw, input logic [13:0] a);
        return {^{rw, a}, rw, a};
    endfunction

    task automatic frame(input logic [15:0] w, input int n);
        spi_host_model_inst.xfer(w, n, ans);
    endtask

    // Answer rides on the following idle read, which has no side effect
    task automatic rd(input logic [13:0] a, output logic [13:0] d);
        frame(cmd(1'b1, a), 16);
        frame(cmd(1'b1, `ADDR_IDLE), 16);
        `CHK("answer parity", 1'b0, ^ans)
        `CHK("out released", 1'b1, serialOutEnN)
        d = ans[13:0];
    endtask

    task automatic ck(input string nm, input logic [13:0] a, input logic [13:0] ex);
        rd(a, val);
        `CHK(nm, ex, val)
    endtask

    task automatic wr(input logic [13:0] a, input logic [13:0] d);
        frame(cmd(1'b0, a), 16);
        frame({^{1'b0, d}, 1'b0, d}, 16);
    endtask

    task automatic do_reset();
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk); // Select must stay high a while after release
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        sensorData = '{8'h80, 1'b1, 1'b0, 14'h1234, 14'h0abc, 14'h0def};
        do_reset();
        // Live values; first gain entry gives the diagnostic reset value
        ck("magnitude", `ADDR_MAGNITUDE, 14'h1234);
        ck("raw angle", `ADDR_RAW_ANGLE, 14'h0abc);
        ck("comp angle", `ADDR_COMP_ANGLE, 14'h0def);
        foreach (gains[i]) begin
            @(negedge clk);
            sensorData.gainValue = gains[i];
            sensorData.loopsDone = gains[i][7];
            sensorData.solverOverflow = gains[i][0];
            ck("diag", `ADDR_DIAG, {2'b00, gains[i] == 8'hff, gains[i] == 8'h00,
                gains[i][0], gains[i][7], gains[i]});
        end
        $display("test live values done");
        // Settings: defaults, masked soft writes, reset drops them
        for (int i = 0; i < 5; i++) begin
            ck("nv default", `ADDR_ZERO_HIGH + 14'(i), 14'h0000);
            wr(`ADDR_ZERO_HIGH + 14'(i), 14'h3fff);
        end
        `CHK("nv out", {8'hff, 8'hff, 8'hdf, 8'h3f, 8'h1f}, nvSettings)
        ck("zero high", `ADDR_ZERO_HIGH, 14'h00ff);
        ck("config one", `ADDR_CONFIG_ONE, 14'h00df);
        ck("comp select", `ADDR_COMP_ANGLE, 14'h0abc);
        wr(`ADDR_RAW_ANGLE, 14'h1111);
        ck("ro write", `ADDR_RAW_ANGLE, 14'h0abc);
        do_reset();
        `CHK("nv reset", 40'h0, nvSettings)
        $display("test settings done");
        // Error flags and the previous-frame error bit
        ck("err none", `ADDR_ERROR, 14'h0000);
        frame(cmd(1'b1, 14'h0005), 16);
        frame(cmd(1'b1, `ADDR_IDLE), 16);
        `CHK("ef set", 1'b1, ans[14])
        frame(cmd(1'b1, `ADDR_IDLE), 16);
        `CHK("ef clear", 1'b0, ans[14])
        ck("bad read", `ADDR_ERROR, 14'h0002);
        ck("err cleared", `ADDR_ERROR, 14'h0000);
        wr(14'h0100, 14'h0000);
        ck("bad write", `ADDR_ERROR, 14'h0002);
        frame(cmd(1'b1, `ADDR_IDLE) ^ 16'h8000, 16);
        ck("parity", `ADDR_ERROR, 14'h0004);
        frame(cmd(1'b1, `ADDR_IDLE), 15);
        ck("short frame", `ADDR_ERROR, 14'h0001);
        frame(cmd(1'b0, `ADDR_ZERO_HIGH), 16);
        frame(16'hc000, 16);
        ck("data rw bit", `ADDR_ERROR, 14'h0001);
        $display("test errors done");
        // One-time burn, verify, reload
        wr(`ADDR_ZERO_HIGH, 14'h005a);
        wr(`ADDR_OTP_CONTROL_REGISTER, 14'h0008);
        `CHK("no burn", 1'b0, otpProgrammed)
        wr(`ADDR_OTP_CONTROL_REGISTER, 14'h0001);
        wr(`ADDR_OTP_CONTROL_REGISTER, 14'h0009);
        `CHK("burned", 1'b1, otpProgrammed)
        ck("otp_control_register strobes", `ADDR_OTP_CONTROL_REGISTER, 14'h0001);
        wr(`ADDR_ZERO_HIGH, 14'h00c3);
        wr(`ADDR_OTP_CONTROL_REGISTER, 14'h0041);
        ck("verify", `ADDR_ZERO_HIGH, 14'h005a);
        wr(`ADDR_OTP_CONTROL_REGISTER, 14'h0005);
        `CHK("reload", 8'h5a, nvSettings.zeroHigh)
        wr(`ADDR_ZERO_HIGH, 14'h00c3);
        wr(`ADDR_OTP_CONTROL_REGISTER, 14'h0009);
        do_reset();
        `CHK("burn kept", 8'h5a, nvSettings.zeroHigh)
        `CHK("flag kept", 1'b1, otpProgrammed)
        $display("test otp done");
        close_out();
    end
endmodule // tb_angle_sensor_register_bank

`default_nettype wire
